//--- pmr_defs.vh
// constants for the phase monitor readback block: register indices,
// field positions, reset values and timing figures.
// assumes inclusion by bare name from the design files.
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH

// =============================================================
// register indices (byte address is four times the index)
`define PMR_IDX_SRC_SEL       10'h04b
`define PMR_IDX_NOISE_WIN    10'h076
`define PMR_IDX_PHASE_LO     10'h077
`define PMR_IDX_PHASE_HI     10'h078
`define PMR_IDX_ALARM_DLY    10'h079

// =============================================================
// field positions
`define PMR_BIT_SRC_SEL      4
`define PMR_BIT_WIN_EN       7
`define PMR_ALARM_MSB        5

// =============================================================
// reset values
`define PMR_RST_SRC_SEL      8'h00
`define PMR_RST_NOISE_WIN    8'h06
`define PMR_RST_PHASE        16'h0000
`define PMR_RST_ALARM_DLY    8'h32

// =============================================================
// timing and filter figures
`define PMR_CLK_HZ           250000000
`define PMR_WIN_PCT          5
`define PMR_CNT_W            17
`define PMR_PD_SAMPLE_HZ     8000
`define PMR_FILT_BW_HZ       100
// shift k gives a bandwidth of about fs / (2*pi*2^k): 8000 Hz, k=4 -> ~80 Hz
`define PMR_FILT_SHIFT       4

// =============================================================
// axi4-lite responses
`define PMR_RESP_OKAY        2'h0
`define PMR_RESP_DECERR      2'h3

`endif

//--- pmr_phase_avg.v
// first-order phase averaging low-pass filter for the readback value.
// assumes one sample strobe per detector update, synchronous reset.
`timescale 1ns/10ps
`include "pmr_defs.vh"

module pmr_phase_avg (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        sample_en,
   input  wire [15:0] phase_in,
   output reg  [15:0] phase_avg
);

   localparam K     = `PMR_FILT_SHIFT;
   localparam ACC_W = 16 + K;

   // =============================================================
   // accumulator holds the average scaled by 2^k
   reg  signed [ACC_W-1:0] acc_r;
   wire signed [ACC_W-1:0] x_ext;
   wire signed [ACC_W-1:0] decay;
   wire signed [ACC_W:0]   sum;

   assign x_ext = {{K{phase_in[15]}}, phase_in};
   assign decay = acc_r >>> K;
   assign sum   = {acc_r[ACC_W-1], acc_r} + {x_ext[ACC_W-1], x_ext}
                - {decay[ACC_W-1], decay};

   always @(posedge aclk) begin
      if (!aresetn) begin
         acc_r     <= {ACC_W{1'b0}};
         phase_avg <= `PMR_RST_PHASE;
      end else begin
         if (sample_en) begin
            acc_r <= sum[ACC_W-1:0];
         end
         phase_avg <= acc_r[ACC_W-1:K];
      end
   end

endmodule

//--- pmr_phase_monitor.v
// phase monitor register bank: edge window for low-frequency references,
// averaged phase error readback and alarm delay field, on axi4-lite.
// assumes all inputs synchronous to aclk; host reads bytes as one pair.
//
// Overview of operation
// - window enabled: low-frequency edges outside 5% of expected time dropped
// - readback comes from main or auxiliary dpll per source select bit
// - selected detector output is averaged by a ~80 Hz low-pass filter
// - phase error is 16-bit signed, low and high bytes read-only
// - noise window bits 6:0 and alarm delay bits 7:6 have no function
// - alarm delay bits 5:0 unsigned, value times two gives seconds
`timescale 1ns/10ps
`include "pmr_defs.vh"

module pmr_phase_monitor (
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // reference edge path
   input  wire        ref_edge,
   input  wire        ref_is_lowfreq,
   output reg         pd_edge,
   output reg         edge_rejected,
   // phase detector outputs
   input  wire        pd_sample,
   input  wire [15:0] main_dpll_phase,
   input  wire [15:0] auxiliary_dpll_phase,
   // alarm delay in seconds for the alarm timer
   output reg  [6:0]  alarm_delay_s
);

   localparam CW = `PMR_CNT_W;
   // window width and percent divisor sized to the tolerance product
   localparam integer  WIN_PCT_I = `PMR_WIN_PCT;
   localparam [CW+2:0] WIN_PCT   = WIN_PCT_I[CW+2:0];
   localparam [CW+2:0] PCT_DIV   = {{(CW-4){1'b0}}, 7'd100};

   // =============================================================
   // helpers
   function hit;
      input [11:0] addr;
      input [9:0]  idx;
      begin
         hit = (addr[11:2] == idx);
      end
   endfunction

   function mapped;
      input [11:0] addr;
      begin
         mapped = hit(addr, `PMR_IDX_SRC_SEL) |
                  hit(addr, `PMR_IDX_NOISE_WIN) |
                  hit(addr, `PMR_IDX_PHASE_LO) |
                  hit(addr, `PMR_IDX_PHASE_HI) |
                  hit(addr, `PMR_IDX_ALARM_DLY);
      end
   endfunction

   // =============================================================
   // registers
   reg  [7:0]    src_sel_r;
   reg  [7:0]    noise_win_r;
   reg  [7:0]    phase_hi_snap_r;
   reg           aw_full_r;
   reg           w_full_r;
   reg  [11:0]   aw_addr_r;
   reg  [7:0]    w_byte_r;
   reg           w_strb_r;
   wire [15:0]   phase_avg;
   wire          win_en;
   wire          readback_source_select;
   wire [7:0]    alarm_cfg;

   assign win_en                 = noise_win_r[`PMR_BIT_WIN_EN];
   assign readback_source_select = src_sel_r[`PMR_BIT_SRC_SEL];
   // alarm delay is read-only: bits 7:6 stay zero, no function
   assign alarm_cfg = `PMR_RST_ALARM_DLY & 8'h3f;

   // =============================================================
   // axi4-lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PMR_RESP_OKAY;
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         aw_addr_r     <= 12'h000;
         w_byte_r      <= 8'h00;
         w_strb_r      <= 1'b0;
         src_sel_r     <= `PMR_RST_SRC_SEL;
         noise_win_r   <= `PMR_RST_NOISE_WIN;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r     <= 1'b1;
            w_byte_r     <= s_axi_wdata[7:0];
            w_strb_r     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (aw_full_r && w_full_r && !s_axi_bvalid) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_r) ? `PMR_RESP_OKAY
                                              : `PMR_RESP_DECERR;
            // phase bytes and alarm delay ignore writes
            if (w_strb_r && hit(aw_addr_r, `PMR_IDX_SRC_SEL)) begin
               src_sel_r <= w_byte_r;
            end
            if (w_strb_r && hit(aw_addr_r, `PMR_IDX_NOISE_WIN)) begin
               noise_win_r <= w_byte_r;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // =============================================================
   // axi4-lite read channel
   // reading the low byte freezes the high byte, so the pair is coherent
   // even though the filter output moves between the two reads
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready   <= 1'b1;
         s_axi_rvalid    <= 1'b0;
         s_axi_rdata     <= 32'h00000000;
         s_axi_rresp     <= `PMR_RESP_OKAY;
         phase_hi_snap_r <= 8'h00;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? `PMR_RESP_OKAY
                                                  : `PMR_RESP_DECERR;
            s_axi_rdata   <= 32'h00000000;
            if (hit(s_axi_araddr, `PMR_IDX_SRC_SEL)) begin
               s_axi_rdata <= {24'h000000, src_sel_r};
            end
            if (hit(s_axi_araddr, `PMR_IDX_NOISE_WIN)) begin
               s_axi_rdata <= {24'h000000, noise_win_r};
            end
            if (hit(s_axi_araddr, `PMR_IDX_PHASE_LO)) begin
               s_axi_rdata     <= {24'h000000, phase_avg[7:0]};
               phase_hi_snap_r <= phase_avg[15:8];
            end
            if (hit(s_axi_araddr, `PMR_IDX_PHASE_HI)) begin
               s_axi_rdata <= {24'h000000, phase_hi_snap_r};
            end
            if (hit(s_axi_araddr, `PMR_IDX_ALARM_DLY)) begin
               s_axi_rdata <= {24'h000000, alarm_cfg};
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // =============================================================
   // phase readback: source select and averaging
   reg  [15:0] pd_sel_r;
   reg         pd_sample_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         pd_sel_r    <= 16'h0000;
         pd_sample_r <= 1'b0;
      end else begin
         pd_sample_r <= pd_sample;
         pd_sel_r    <= readback_source_select ? auxiliary_dpll_phase
                                               : main_dpll_phase;
      end
   end

   pmr_phase_avg u_avg (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sample_en (pd_sample_r),
      .phase_in  (pd_sel_r),
      .phase_avg (phase_avg)
   );

   // =============================================================
   // edge window for low-frequency references
   // expected time is the last accepted spacing; a missed edge slides the
   // expectation one period on, so a single dropout does not lock it out
   reg  [CW-1:0] cnt_r;
   reg  [CW-1:0] per_r;
   wire [CW+2:0] tol_wide;
   wire [CW-1:0] tol;
   wire [CW:0]   lo_lim;
   wire [CW:0]   hi_lim;
   wire          in_win;
   wire          filt_on;

   assign tol_wide = ({3'h0, per_r} * WIN_PCT) / PCT_DIV;
   assign tol      = tol_wide[CW-1:0];
   assign lo_lim   = {1'b0, per_r} - {1'b0, tol};
   assign hi_lim   = {1'b0, per_r} + {1'b0, tol};
   assign in_win   = ({1'b0, cnt_r} >= lo_lim) && ({1'b0, cnt_r} <= hi_lim);
   assign filt_on  = win_en && ref_is_lowfreq && (per_r != {CW{1'b0}});

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r         <= {CW{1'b0}};
         per_r         <= {CW{1'b0}};
         pd_edge       <= 1'b0;
         edge_rejected <= 1'b0;
      end else begin
         pd_edge       <= 1'b0;
         edge_rejected <= 1'b0;
         if (cnt_r != {CW{1'b1}}) begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
         end
         if (ref_edge) begin
            if (!filt_on || in_win) begin
               pd_edge <= 1'b1;
               per_r   <= cnt_r;
               cnt_r   <= {CW{1'b0}};
            end else begin
               edge_rejected <= 1'b1;
            end
         end else if (filt_on && ({1'b0, cnt_r} > hi_lim)) begin
            cnt_r <= cnt_r - per_r - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

   // =============================================================
   // alarm delay in seconds
   always @(posedge aclk) begin
      if (!aresetn) begin
         alarm_delay_s <= 7'h00;
      end else begin
         alarm_delay_s <= {alarm_cfg[`PMR_ALARM_MSB:0], 1'b0};
      end
   end

endmodule

//--- pmr_host_model.sv
// host software model: axi4-lite master for register access.
// assumes one slave on the bus; the bench bounds every wait.
`timescale 1ns/10ps
module pmr_host_model (
   input  wire         aclk,
   output logic [11:0] s_axi_awaddr,
   output logic        s_axi_awvalid,
   input  wire         s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input  wire         s_axi_wready,
   input  wire  [1:0]  s_axi_bresp,
   input  wire         s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic        s_axi_arvalid,
   input  wire         s_axi_arready,
   input  wire  [31:0] s_axi_rdata,
   input  wire  [1:0]  s_axi_rresp,
   input  wire         s_axi_rvalid,
   output logic        s_axi_rready
);
   real phase_scaled;
   // ====
   // bus cycles
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_wstrb = 4'hf;
   end
   task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // low byte first: it freezes the high byte for a coherent pair
   task automatic rd_phase(output [15:0] v);
      logic [31:0] lo, hi;
      logic [1:0]  r;
      rd(12'h1dc, lo, r);
      rd(12'h1e0, hi, r);
      v = {hi[7:0], lo[7:0]};
      phase_scaled = $itor($signed(v)) * 0.707;
   endtask
endmodule

//--- pmr_phase_monitor_assertions.sv
// checker for the phase monitor register bank, bound to its top.
// assumes one clock domain with synchronous active-low reset.
`timescale 1ns/10ps
module pmr_chk (
   input logic        aclk,
   input logic        aresetn,
   input logic [11:0] s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        ref_edge,
   input logic        ref_is_lowfreq,
   input logic        pd_edge,
   input logic        edge_rejected,
   input logic [6:0]  alarm_delay_s
);
   // ====
   // properties
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_alarm; $past(aresetn) |-> alarm_delay_s == 7'd100; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm delay");
   property p_alm_rd;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h1e4
      |=> s_axi_rvalid && s_axi_rdata == 32'h32;
   endproperty
   a_alm_rd: assert property (p_alm_rd) else $error("alarm read");
   property p_edge_one; ref_edge |=> pd_edge != edge_rejected; endproperty
   a_edge_one: assert property (p_edge_one) else $error("edge");
   property p_no_edge; !ref_edge |=> !pd_edge && !edge_rejected; endproperty
   a_no_edge: assert property (p_no_edge) else $error("no edge");
   property p_hf_pass; ref_edge && !ref_is_lowfreq |=> pd_edge; endproperty
   a_hf_pass: assert property (p_hf_pass) else $error("hf edge");
   property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("rdata upper");
   property p_dec;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0
      |=> s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
   endproperty
   a_dec: assert property (p_dec) else $error("decerr");
endmodule
bind pmr_phase_monitor pmr_chk i_chk (
   .aclk           (aclk),
   .aresetn        (aresetn),
   .s_axi_araddr   (s_axi_araddr),
   .s_axi_arvalid  (s_axi_arvalid),
   .s_axi_arready  (s_axi_arready),
   .s_axi_rdata    (s_axi_rdata),
   .s_axi_rresp    (s_axi_rresp),
   .s_axi_rvalid   (s_axi_rvalid),
   .ref_edge       (ref_edge),
   .ref_is_lowfreq (ref_is_lowfreq),
   .pd_edge        (pd_edge),
   .edge_rejected  (edge_rejected),
   .alarm_delay_s  (alarm_delay_s)
);

//--- tb_phase_monitor_readback.sv
// self-checking bench for the phase monitor register bank.
// assumes the host model and checker files compile first.
`timescale 1ns/10ps
module tb_phase_monitor_readback;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, pd_edge, edge_rejected;
   logic        ref_edge = 1'b0, ref_is_lowfreq = 1'b0, pd_sample = 1'b0;
   logic [15:0] main_dpll_phase = 16'h0, auxiliary_dpll_phase = 16'h0, v;
   logic [6:0]  alarm_delay_s;
   int          num_errors = 0, tests_run = 0, cyc = 0;
   logic [43:0] regs [5] = '{44'h12c_00000000, 44'h1d8_00000006,
                             44'h1dc_00000000, 44'h1e0_00000000,
                             44'h1e4_00000032};
   logic [51:0] rows [3] = '{52'h0_1234_f000_1234, 52'h1_1234_f000_f000,
                             52'h0_8100_0100_8100};
   // gaps in cycles; the enabling write before row 2 adds 4 cycles, so
   // every gap is 100 except the first (7), a dropout (200), a slow edge (102), noise and the last, high-frequency edge (5)
   int          eg [10] = '{7, 100, 96, 50, 50, 200, 102, 60, 42, 5};
   int          eok [10] = '{1, 1, 1, 0, 1, 1, 1, 0, 1, 1};
   pmr_phase_monitor i_dut (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .s_axi_awaddr         (s_axi_awaddr),
      .s_axi_awvalid        (s_axi_awvalid),
      .s_axi_awready        (s_axi_awready),
      .s_axi_wdata          (s_axi_wdata),
      .s_axi_wstrb          (s_axi_wstrb),
      .s_axi_wvalid         (s_axi_wvalid),
      .s_axi_wready         (s_axi_wready),
      .s_axi_bresp          (s_axi_bresp),
      .s_axi_bvalid         (s_axi_bvalid),
      .s_axi_bready         (s_axi_bready),
      .s_axi_araddr         (s_axi_araddr),
      .s_axi_arvalid        (s_axi_arvalid),
      .s_axi_arready        (s_axi_arready),
      .s_axi_rdata          (s_axi_rdata),
      .s_axi_rresp          (s_axi_rresp),
      .s_axi_rvalid         (s_axi_rvalid),
      .s_axi_rready         (s_axi_rready),
      .ref_edge             (ref_edge),
      .ref_is_lowfreq       (ref_is_lowfreq),
      .pd_edge              (pd_edge),
      .edge_rejected        (edge_rejected),
      .pd_sample            (pd_sample),
      .main_dpll_phase      (main_dpll_phase),
      .auxiliary_dpll_phase (auxiliary_dpll_phase),
      .alarm_delay_s        (alarm_delay_s)
   );
   pmr_host_model i_host (
      .aclk          (aclk),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready)
   );
   // ====
   // helpers
   task automatic check(input string n, input [39:0] s, input [39:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic near(input [15:0] a, input [15:0] b);
      logic signed [16:0] df;
      df = $signed(a) - $signed(b);
      return df <= 16 && df >= -16;
   endfunction
   task automatic samples(input int n);
      repeat (n) begin
         @(posedge aclk);
         pd_sample <= 1'b1;
         @(posedge aclk);
         pd_sample <= 1'b0;
      end
      repeat (4) @(posedge aclk);
   endtask
   // ok 2: edge only trains the period, outcome left open
   task automatic edge_at(input int g, input bit lf, input int ok);
      repeat (g - 1) @(posedge aclk);
      ref_edge <= 1'b1;
      ref_is_lowfreq <= lf;
      @(posedge aclk);
      ref_edge <= 1'b0;
      #1;
      if (ok < 2) check("edge", {pd_edge, edge_rejected}, ok ? 2 : 1);
   endtask
   // ====
   // sequence
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      check("alarm_delay_s", alarm_delay_s, 100);
      foreach (regs[i]) begin
         i_host.rd(regs[i][43:32], d, r);
         check("reset value", {r, d}, {2'h0, regs[i][31:0]});
      end
      i_host.rd(12'h000, d, r);
      check("unmapped read", {r, d}, {2'h3, 32'h0});
      i_host.wr(12'h000, 32'h1, r);
      check("unmapped write", r, 2'h3);
      i_host.wr(12'h1dc, 32'hab, r);
      i_host.wr(12'h1e4, 32'hff, r);
      i_host.rd_phase(v);
      check("phase ro", v, 16'h0);
      i_host.rd(12'h1e4, d, r);
      check("alarm ro", {d, alarm_delay_s}, {32'h32, 7'd100});
      main_dpll_phase <= 16'h4000;
      samples(1);
      i_host.rd_phase(v);
      check("filter step", v > 16'h0 && v < 16'h2000, 1);
      foreach (rows[i]) begin
         i_host.wr(12'h12c, {27'h0, rows[i][48], 4'h0}, r);
         main_dpll_phase <= rows[i][47:32];
         auxiliary_dpll_phase <= rows[i][31:16];
         samples(200);
         i_host.rd_phase(v);
         check("phase", near(v, rows[i][15:0]), 1);
      end
      foreach (eg[i]) begin
         if (i == 2) i_host.wr(12'h1d8, 32'h80, r);
         edge_at(eg[i], i != 9, eok[i]);
      end
      give_verdict();
   end
endmodule
